/* cpu_regfile_pkg.sv */
package cpu_regfile_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned NUM_REGS = 16;
    localparam logic [3:0] PC_IDX = 4'h0;
    localparam logic [3:0] FIRST_GP_IDX = 4'h4;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] WORD_ALIGN_MASK = 16'hFFFE;
    localparam logic [15:0] BYTE_MASK = 16'h00FF;
    localparam int unsigned BYTE_W = 8;
    // instruction length codes, in words
    localparam logic [1:0] LEN_ONE_WORD = 2'h1;
    localparam logic [1:0] LEN_TWO_WORDS = 2'h2;
    localparam logic [1:0] LEN_THREE_WORDS = 2'h3;
endpackage : cpu_regfile_pkg

/* operand_stage.sv */
`timescale 1ns/1ps
// holds one memory operand off the visible register file
module operand_stage #(
    parameter int unsigned DATA_W = cpu_regfile_pkg::DATA_W
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic capture_i,
    input wire logic byte_i,
    input wire logic lane_hi_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic [DATA_W-1:0] value_o
);
    logic [DATA_W-1:0] value_q;
    logic [DATA_W-1:0] value_d;
    wire logic [DATA_W-1:0] lane_byte;

    // byte operands come from the addressed lane and are zero-extended
    assign lane_byte = lane_hi_i ? {{(DATA_W/2){1'b0}}, rdata_i[DATA_W-1:DATA_W/2]}
                                 : {{(DATA_W/2){1'b0}}, rdata_i[DATA_W/2-1:0]};
    assign value_d = capture_i ? (byte_i ? lane_byte : rdata_i) : value_q;

    // staging register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            value_q <= '0;
        end else begin
            value_q <= value_d;
        end
    end

    assign value_o = value_q;
endmodule : operand_stage

/* cpu_register_file_pc.sv */
`timescale 1ns/1ps
// Overview of operation
// - sixteen 16-bit registers, picked by a 4-bit index 0 to 15
// - registers 0..3 dedicated, 4..15 plain storage without side effects
// - register 0 is the pointer to the next instruction to fetch
// - pointer advances by instruction length: two, four or six bytes
// - fetches are word aligned in 64 KB; pointer bit 0 always zero
// - pointer is readable and writable by any instruction; write means branch
// - 16-bit address bus reaches all memory directly, no paging
// - 16-bit data bus moves a full word in one transfer
// - memory-to-memory moves pass through a hidden stage, not a register
// - registers and memory accept byte and word operand sizes
module cpu_register_file_pc #(
    parameter int unsigned DATA_W = cpu_regfile_pkg::DATA_W,
    parameter int unsigned ADDR_W = cpu_regfile_pkg::ADDR_W,
    parameter int unsigned NUM_REGS = cpu_regfile_pkg::NUM_REGS
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register read ports, one cycle latency
    input wire logic [3:0] rd_a_idx_i,
    input wire logic [3:0] rd_b_idx_i,
    output logic [DATA_W-1:0] rd_a_data_o,
    output logic [DATA_W-1:0] rd_b_data_o,
    // register write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_idx_i,
    input wire logic wr_byte_i,
    input wire logic wr_from_mem_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    // instruction stepping
    input wire logic pc_step_i,
    input wire logic [1:0] pc_len_words_i,
    output logic [ADDR_W-1:0] next_instruction_pointer_o,
    // data access requests
    input wire logic dacc_req_i,
    input wire logic dacc_wr_i,
    input wire logic dacc_byte_i,
    input wire logic dacc_m2m_i,
    input wire logic [ADDR_W-1:0] dacc_addr_i,
    input wire logic [DATA_W-1:0] dacc_wdata_i,
    // memory bus
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic mem_byte_o,
    input wire logic [DATA_W-1:0] mem_rdata_i
);
    // slot 0 is reset but never used: index 0 always means the pointer
    logic [DATA_W-1:0] regs_q [NUM_REGS];
    logic [ADDR_W-1:0] pc_q;
    logic [ADDR_W-1:0] pc_d;
    logic [DATA_W-1:0] rd_a_q;
    logic [DATA_W-1:0] rd_b_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [DATA_W-1:0] mem_wdata_q;
    logic mem_rd_q;
    logic mem_wr_q;
    logic mem_byte_q;
    logic [DATA_W-1:0] staged;

    // forces a value onto a word boundary
    function automatic logic [ADDR_W-1:0] word_align(input logic [ADDR_W-1:0] a);
        word_align = a & cpu_regfile_pkg::WORD_ALIGN_MASK;
    endfunction : word_align

    // byte write clears the upper byte so later word reads see a clean value
    function automatic logic [DATA_W-1:0] size_value(input logic [DATA_W-1:0] v,
                                                     input logic is_byte);
        size_value = is_byte ? (v & cpu_regfile_pkg::BYTE_MASK) : v;
    endfunction : size_value

    // index 0 is the pointer; decoded in the write and the read paths alike
    function automatic logic is_pointer_idx(input logic [3:0] idx);
        is_pointer_idx = (idx == cpu_regfile_pkg::PC_IDX);
    endfunction : is_pointer_idx

    // read selection: index 0 returns the pointer itself
    function automatic logic [DATA_W-1:0] read_reg(input logic [3:0] idx,
                                                   input logic [ADDR_W-1:0] pc,
                                                   input logic [DATA_W-1:0] r [NUM_REGS]);
        read_reg = is_pointer_idx(idx) ? pc : r[idx];
    endfunction : read_reg

    // byte stores put the low byte on both lanes; memory picks the lane by address bit 0
    function automatic logic [DATA_W-1:0] both_lanes(input logic [DATA_W-1:0] v);
        both_lanes = {2{v[cpu_regfile_pkg::BYTE_W-1:0]}};
    endfunction : both_lanes

    // named selections; everything below up to the flops is plain decode
    wire logic [DATA_W-1:0] wr_src;
    wire logic [DATA_W-1:0] wr_value;
    wire logic pc_write;
    wire logic [ADDR_W-1:0] step_bytes;
    wire logic [ADDR_W-1:0] pc_stepped;
    wire logic gp_write;
    wire logic capture;
    wire logic [DATA_W-1:0] mem_wdata_d;
    wire logic [DATA_W-1:0] byte_wdata;
    wire logic [DATA_W-1:0] m2m_wdata;
    wire logic [DATA_W-1:0] cpu_wdata;
    wire logic [ADDR_W-1:0] pc_branch;
    wire logic [DATA_W-1:0] rd_a_d;
    wire logic [DATA_W-1:0] rd_b_d;
    wire logic [ADDR_W-1:0] mem_addr_d;
    wire logic mem_rd_d;
    wire logic mem_wr_d;
    wire logic mem_byte_d;

    // write source and size selection
    assign wr_src = wr_from_mem_i ? staged : wr_data_i;
    assign wr_value = size_value(wr_src, wr_byte_i);
    assign pc_write = wr_en_i && is_pointer_idx(wr_idx_i);
    assign gp_write = wr_en_i && !is_pointer_idx(wr_idx_i);

    // pointer next value; an explicit write beats stepping so only one update lands,
    // and the sum wraps within the 64 KB space
    assign step_bytes = {{(ADDR_W-3){1'b0}}, pc_len_words_i, 1'b0};
    assign pc_stepped = ADDR_W'(pc_q + step_bytes);
    assign pc_branch = word_align(wr_value);
    assign pc_d = pc_write ? pc_branch
                : (pc_step_i ? word_align(pc_stepped) : pc_q);

    // pointer register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pc_q <= cpu_regfile_pkg::PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // registers 1..15; the dedicated ones 1..3 get their roles from the execution unit
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= cpu_regfile_pkg::REG_RESET;
            end
        end else if (gp_write) begin
            regs_q[wr_idx_i] <= wr_value;
        end
    end

    // read selection; a write in the same cycle is not forwarded, so a register
    // written at one edge is read back from the next edge on
    assign rd_a_d = read_reg(rd_a_idx_i, pc_q, regs_q);
    assign rd_b_d = read_reg(rd_b_idx_i, pc_q, regs_q);

    // registered read ports
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rd_a_q <= '0;
            rd_b_q <= '0;
        end else begin
            rd_a_q <= rd_a_d;
            rd_b_q <= rd_b_d;
        end
    end

    // memory data: byte stores are replicated on both lanes, memory picks by address
    assign byte_wdata = both_lanes(dacc_wdata_i);
    assign m2m_wdata = dacc_byte_i ? both_lanes(staged) : staged;
    assign cpu_wdata = dacc_byte_i ? byte_wdata : dacc_wdata_i;
    assign mem_wdata_d = dacc_m2m_i ? m2m_wdata : cpu_wdata;

    // bus command decode; address and size hold between requests; the stage picks
    // its lane in the strobe cycle, at the edge where the strobe drops
    assign mem_rd_d = dacc_req_i && !dacc_wr_i;
    assign mem_wr_d = dacc_req_i && dacc_wr_i;
    assign mem_addr_d = dacc_req_i ? dacc_addr_i : mem_addr_q;
    assign mem_byte_d = dacc_req_i ? dacc_byte_i : mem_byte_q;

    // bus strobes, one cycle per request
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
        end else begin
            mem_rd_q <= mem_rd_d;
            mem_wr_q <= mem_wr_d;
        end
    end

    // bus payload register; full 16-bit address, no paging
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
            mem_byte_q <= 1'b0;
        end else begin
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wr_d ? mem_wdata_d : mem_wdata_q;
            mem_byte_q <= mem_byte_d;
        end
    end

    // read data is sampled in the strobe cycle itself; the staged copy can
    // feed a register or a memory-to-memory store from the cycle after that
    assign capture = mem_rd_q;

    // hidden operand stage keeps memory-to-memory moves off the visible registers
    operand_stage #(
        .DATA_W(DATA_W)
    ) u_stage (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .capture_i(capture),
        .byte_i(mem_byte_q),
        .lane_hi_i(mem_addr_q[0]),
        .rdata_i(mem_rdata_i),
        .value_o(staged)
    );

    assign rd_a_data_o = rd_a_q;
    assign rd_b_data_o = rd_b_q;
    assign next_instruction_pointer_o = pc_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign mem_rd_o = mem_rd_q;
    assign mem_wr_o = mem_wr_q;
    assign mem_byte_o = mem_byte_q;
endmodule : cpu_register_file_pc

/* rf_checker_assertions.sv */
`timescale 1ns/1ps
// pointer and data bus behaviour seen from the ports
module rf_checker (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic wr_en_i,
    input wire logic wr_byte_i,
    input wire logic wr_from_mem_i,
    input wire logic pc_step_i,
    input wire logic dacc_req_i,
    input wire logic dacc_wr_i,
    input wire logic dacc_byte_i,
    input wire logic dacc_m2m_i,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic mem_byte_o,
    input wire logic [3:0] wr_idx_i,
    input wire logic [1:0] pc_len_words_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [15:0] dacc_addr_i,
    input wire logic [15:0] dacc_wdata_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic [15:0] mem_wdata_o,
    input wire logic [15:0] next_instruction_pointer_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // short aliases so each property fits on two lines
    wire [15:0] p = next_instruction_pointer_o;
    wire pw = wr_en_i && wr_idx_i == 4'h0;
    wire wq = dacc_req_i && dacc_wr_i && !dacc_m2m_i;
    wire [7:0] lo = dacc_wdata_i[7:0];
    ptr_even_a: assert property (p[0] == 1'b0) else $error("odd pointer");
    ptr_step_a: assert property (pc_step_i && !pw |=>
        p == $past(p) + {$past(pc_len_words_i), 1'b0}) else $error("bad step");
    ptr_branch_a: assert property (pw && !wr_from_mem_i |=>
        p == ($past(wr_data_i) & ($past(wr_byte_i) ? 16'h00FE : 16'hFFFE))) else $error("branch");
    ptr_hold_a: assert property (!pc_step_i && !pw |=> $stable(p))
        else $error("pointer moved");
    rd_strobe_a: assert property (dacc_req_i && !dacc_wr_i |=>
        mem_rd_o && !mem_wr_o && mem_addr_o == $past(dacc_addr_i)) else $error("bad read");
    wr_word_a: assert property (wq && !dacc_byte_i |=>
        mem_wr_o && !mem_byte_o && mem_wdata_o == $past(dacc_wdata_i)) else $error("bad write");
    wr_byte_a: assert property (wq && dacc_byte_i |=>
        mem_byte_o && mem_wdata_o == {2{$past(lo)}}) else $error("bad byte write");
    idle_strobe_a: assert property (!dacc_req_i |=> !mem_rd_o && !mem_wr_o)
        else $error("stray strobe");
    cover property (pc_step_i && pc_len_words_i == 2'h3);
    cover property (dacc_req_i && dacc_m2m_i);
    cover property (pw && pc_step_i);
endmodule : rf_checker

bind cpu_register_file_pc rf_checker chk (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(wr_en_i),
    .wr_byte_i(wr_byte_i),
    .wr_from_mem_i(wr_from_mem_i),
    .pc_step_i(pc_step_i),
    .dacc_req_i(dacc_req_i),
    .dacc_wr_i(dacc_wr_i),
    .dacc_byte_i(dacc_byte_i),
    .dacc_m2m_i(dacc_m2m_i),
    .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o),
    .mem_byte_o(mem_byte_o),
    .wr_idx_i(wr_idx_i),
    .pc_len_words_i(pc_len_words_i),
    .wr_data_i(wr_data_i),
    .dacc_addr_i(dacc_addr_i),
    .dacc_wdata_i(dacc_wdata_i),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .next_instruction_pointer_o(next_instruction_pointer_o)
);

/* mem_model.sv */
`timescale 1ns/1ps
// sixteen-word memory; an idle bus shows the inverse of the last word, so stale data fails
module mem_model (
    input wire logic sys_clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic byte_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    logic [15:0] word_q [16];
    logic [15:0] last_q = 16'h0000;
    assign rdata_o = rd_i ? word_q[addr_i[4:1]] : ~last_q;
    // lanes stored apart so a wrong byte lane shows on read back
    always_ff @(posedge sys_clk_i) begin
        if (rd_i) last_q <= rdata_o;
        if (wr_i && !(byte_i && addr_i[0])) word_q[addr_i[4:1]][7:0] <= wdata_i[7:0];
        if (wr_i && !(byte_i && !addr_i[0])) word_q[addr_i[4:1]][15:8] <= wdata_i[15:8];
    end
endmodule : mem_model

/* cpu_register_file_pc_tb.sv */
`timescale 1ns/1ps
module cpu_register_file_pc_tb;
    logic sys_clk_i = 1'b0;
    logic nrst_i, wr_en_i, wr_byte_i, wr_from_mem_i, pc_step_i, mem_rd_o, mem_wr_o, mem_byte_o;
    logic dacc_req_i, dacc_wr_i, dacc_byte_i, dacc_m2m_i;
    logic [3:0] rd_a_idx_i, rd_b_idx_i, wr_idx_i;
    logic [1:0] pc_len_words_i;
    logic [15:0] rd_a_data_o, rd_b_data_o, wr_data_i, dacc_addr_i, dacc_wdata_i, mem_rdata_i;
    logic [15:0] next_instruction_pointer_o, mem_addr_o, mem_wdata_o;
    wire [15:0] ptr = next_instruction_pointer_o;
    int n_mismatch = 0;
    int compares = 0;
    cpu_register_file_pc uut (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .rd_a_idx_i(rd_a_idx_i),
        .rd_b_idx_i(rd_b_idx_i),
        .rd_a_data_o(rd_a_data_o),
        .rd_b_data_o(rd_b_data_o),
        .wr_en_i(wr_en_i),
        .wr_idx_i(wr_idx_i),
        .wr_byte_i(wr_byte_i),
        .wr_from_mem_i(wr_from_mem_i),
        .wr_data_i(wr_data_i),
        .pc_step_i(pc_step_i),
        .pc_len_words_i(pc_len_words_i),
        .next_instruction_pointer_o(next_instruction_pointer_o),
        .dacc_req_i(dacc_req_i),
        .dacc_wr_i(dacc_wr_i),
        .dacc_byte_i(dacc_byte_i),
        .dacc_m2m_i(dacc_m2m_i),
        .dacc_addr_i(dacc_addr_i),
        .dacc_wdata_i(dacc_wdata_i),
        .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o),
        .mem_byte_o(mem_byte_o),
        .mem_rdata_i(mem_rdata_i)
    );
    mem_model mem (.sys_clk_i(sys_clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .byte_i(mem_byte_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    // 25 MHz clock
    initial forever #20 sys_clk_i = ~sys_clk_i;
    task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
        compares++;
        if (g !== x) n_mismatch++;
        if (g !== x) $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    endtask : cmp
    // inputs change on the falling edge, away from the sampling edge
    task automatic wr(input logic [3:0] i, input logic [15:0] d, input logic b, m);
        {wr_en_i, wr_idx_i, wr_data_i, wr_byte_i, wr_from_mem_i} = {1'b1, i, d, b, m};
        @(negedge sys_clk_i);
        wr_en_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] i, input logic [15:0] x);
        {rd_a_idx_i, rd_b_idx_i} = {i, i};
        @(negedge sys_clk_i);
        cmp("read a", x, rd_a_data_o);
        cmp("read b", x, rd_b_data_o);
    endtask : rd
    // second cycle lets a read land in the hidden stage
    task automatic acc(input logic w, b, m, input logic [15:0] a, d);
        {dacc_req_i, dacc_wr_i, dacc_byte_i, dacc_m2m_i, dacc_addr_i, dacc_wdata_i} =
            {1'b1, w, b, m, a, d};
        @(negedge sys_clk_i);
        cmp("bus read strobe", 16'(!w), 16'(mem_rd_o));
        cmp("bus write strobe", 16'(w), 16'(mem_wr_o));
        cmp("bus address", a, mem_addr_o);
        cmp("bus size", 16'(b), 16'(mem_byte_o));
        if (w && !m) cmp("bus write data", b ? {2{d[7:0]}} : d, mem_wdata_o);
        dacc_req_i = 1'b0;
        @(negedge sys_clk_i);
        cmp("bus strobes idle", 16'h0000, 16'({mem_rd_o, mem_wr_o}));
    endtask : acc
    // a reset in mid-run clears pointer, registers and bus outputs
    task automatic reset_test();
        nrst_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        cmp("pointer after reset", 16'h0000, ptr);
        cmp("bus address after reset", 16'h0000, mem_addr_o);
        cmp("bus data after reset", 16'h0000, mem_wdata_o);
        rd(4'h5, 16'h0000);
    endtask : reset_test
    task automatic regs_test();
        for (int i = 1; i < 16; i++) begin
            wr(4'(i), 16'hA500 | 16'(i), 1'b0, 1'b0);
            @(negedge sys_clk_i);
        end
        for (int i = 1; i < 16; i++) rd(4'(i), 16'hA500 | 16'(i));
        wr(4'h4, 16'h1234, 1'b1, 1'b0);
        rd(4'h4, 16'h0034);
    endtask : regs_test
    task automatic pc_test();
        for (int l = 1; l < 4; l++) begin
            {pc_step_i, pc_len_words_i} = {1'b1, 2'(l)};
            @(negedge sys_clk_i);
            cmp("pointer", 16'(l * (l + 1)), ptr);
        end
        pc_step_i = 1'b0;
        rd(4'h0, 16'h000C);
        wr(4'h0, 16'h1235, 1'b0, 1'b0);
        cmp("pointer", 16'h1234, ptr);
        @(negedge sys_clk_i);
        cmp("pointer held", 16'h1234, ptr);
        pc_step_i = 1'b1;
        wr(4'h0, 16'hFFFE, 1'b0, 1'b0);
        cmp("pointer", 16'hFFFE, ptr);
        @(negedge sys_clk_i);
        pc_step_i = 1'b0;
        cmp("pointer", 16'h0004, ptr);
    endtask : pc_test
    task automatic mem_test();
        acc(1'b1, 1'b0, 1'b0, 16'h0010, 16'hBEEF);
        acc(1'b1, 1'b1, 1'b0, 16'h0013, 16'h5577);
        acc(1'b0, 1'b0, 1'b0, 16'h0010, 16'h0000);
        acc(1'b1, 1'b0, 1'b1, 16'h0020, 16'h0000);
        acc(1'b0, 1'b0, 1'b0, 16'h0020, 16'h0000);
        wr(4'h5, 16'h0000, 1'b0, 1'b1);
        rd(4'h5, 16'hBEEF);
        acc(1'b0, 1'b1, 1'b0, 16'h0013, 16'h0000);
        wr(4'h6, 16'hFFFF, 1'b0, 1'b1);
        rd(4'h6, 16'h0077);
    endtask : mem_test
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // reset for four cycles, then the scenarios in turn
    initial begin
        {nrst_i, wr_en_i, wr_byte_i, wr_from_mem_i, pc_step_i, pc_len_words_i, wr_idx_i} = '0;
        {dacc_req_i, dacc_wr_i, dacc_byte_i, dacc_m2m_i, dacc_addr_i, dacc_wdata_i} = '0;
        {rd_a_idx_i, rd_b_idx_i, wr_data_i} = '0;
        repeat (4) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        cmp("pointer", 16'h0000, ptr);
        regs_test();
        pc_test();
        mem_test();
        reset_test();
        give_verdict();
    end
endmodule : cpu_register_file_pc_tb
